//--- shared/lane_health_pkg.sv
// Package: register map, field layouts and carriers of the lane link status bank
package lane_health_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned ADR_W = 14;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LINK_NUM = 2;
  localparam int unsigned PAGE_W = 1;
  localparam int unsigned EVT_W = 11;

  // ----------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [IDX_W-1:0] IDX_PAGE = 12'h0300;
  localparam logic [IDX_W-1:0] IDX_LANE_ONE = 12'h04b1;
  localparam logic [IDX_W-1:0] IDX_LANE_TWO = 12'h04b2;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 12'h04c0;
  localparam logic [IDX_W-1:0] IDX_EVT_CLEAR = 12'h04c1;
  localparam logic [IDX_W-1:0] IDX_EVT_ENABLE = 12'h04c2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [BYTE_W-1:0] RST_STATUS = 8'h00;
  localparam logic [PAGE_W-1:0] RST_PAGE = 1'h0;
  localparam logic [EVT_W-1:0] RST_EVT = 11'h000;
  localparam logic [DAT_W-1:0] RST_DATA = 32'h0000_0000;

  // ----------------------------------------
  // Live lane state from the receiver, one set per link
  // ----------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] disparityCnt;
    logic [CNT_W-1:0] tableMissCnt;
    logic [CNT_W-1:0] badCtrlCnt;
    logic deskewDone;
    logic initialSyncOk;
    logic configSumOk;
    logic frameLock;
    logic charGroupLock;
  } lane_two_live_s;

  typedef struct packed {
    logic configSumOk;
    logic frameLock;
    logic charGroupLock;
  } lane_one_live_s;

  typedef struct packed {
    lane_one_live_s laneOne;
    lane_two_live_s laneTwo;
  } link_live_s;

  // ----------------------------------------
  // Status byte layouts, bit 7 first
  // ----------------------------------------
  typedef struct packed {
    logic disparityErr;
    logic tableMissErr;
    logic badControlCharErr;
    logic deskewDone;
    logic initialSyncOk;
    logic configSumOk;
    logic frameLock;
    logic charGroupLock;
  } lane_two_byte_s;

  typedef struct packed {
    logic [4:0] unused;
    logic configSumOk;
    logic frameLock;
    logic charGroupLock;
  } lane_one_byte_s;

  // Event bits: lane-one byte low three bits above the lane-two byte
  typedef struct packed {
    logic [2:0] laneOne;
    logic [BYTE_W-1:0] laneTwo;
  } event_vec_s;

endpackage

//--- design/lane_error_compare.sv
// Threshold comparison of the three lane error counts
`timescale 1ns/100ps
module lane_error_compare #(
  parameter int unsigned CNT_W = 8
) (
  // Counts
  input wire logic [CNT_W-1:0] disparityCnt,
  input wire logic [CNT_W-1:0] tableMissCnt,
  input wire logic [CNT_W-1:0] badCtrlCnt,
  // Threshold
  input wire logic [CNT_W-1:0] errorCountThreshold,
  // Flags
  output logic disparityErr,
  output logic tableMissErr,
  output logic badControlCharErr
);

  // ----------------------------------------
  // At or above the threshold flags the error
  // ----------------------------------------
  assign disparityErr = (disparityCnt >= errorCountThreshold); // R01
  assign tableMissErr = (tableMissCnt >= errorCountThreshold); // R02
  assign badControlCharErr = (badCtrlCnt >= errorCountThreshold); // R03

endmodule

//--- design/serial_lane_link_status.sv
// Paged lane link status registers with a classic Wishbone slave
//
// Overview of operation
// R01: Lane-two bit 7: disparity count at/above threshold.
// R02: Lane-two bit 6: table-miss count at/above threshold.
// R03: Lane-two bit 5: bad control count at/above threshold.
// R04: Lane-two bit 4: one when deskew achieved.
// R05: Lane-two bit 3: one while initial sync held.
// R06: Lane-two bit 2: one when config checksum correct.
// R07: Lane-two bit 1: one while frame sync held.
// R08: Lane-two bit 0: one while code group sync.
// R09: Lane-one bits 2..0: checksum, frame, code group.
// R10: Read-only, reset zero, paged by link select.
// R11: Writes ignored; bits track live state continuously.
`timescale 1ns/100ps
module serial_lane_link_status #(
  parameter int unsigned LINK_NUM = lane_health_pkg::LINK_NUM,
  parameter int unsigned CNT_W = lane_health_pkg::CNT_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lane_health_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [lane_health_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [lane_health_pkg::DAT_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [lane_health_pkg::DAT_W-1:0] wb_dat_o,
  // Live receiver state, one set per link
  input wire lane_health_pkg::link_live_s linkLive [LINK_NUM],
  // Error threshold from the threshold register
  input wire logic [CNT_W-1:0] errorCountThreshold,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  lane_health_pkg::lane_two_byte_s linkTwoByte [LINK_NUM];
  lane_health_pkg::lane_one_byte_s linkOneByte [LINK_NUM];

  lane_health_pkg::lane_two_byte_s laneTwoSel;
  lane_health_pkg::lane_one_byte_s laneOneSel;

  logic [lane_health_pkg::BYTE_W-1:0] laneTwoHealth_reg;
  logic [lane_health_pkg::BYTE_W-1:0] laneTwoHealth_next;
  logic [lane_health_pkg::BYTE_W-1:0] laneOneHealth_reg;
  logic [lane_health_pkg::BYTE_W-1:0] laneOneHealth_next;

  logic [lane_health_pkg::PAGE_W-1:0] linkPage_reg;
  logic [lane_health_pkg::PAGE_W-1:0] linkPage_next;

  logic [lane_health_pkg::EVT_W-1:0] evtStatus_reg;
  logic [lane_health_pkg::EVT_W-1:0] evtStatus_next;
  logic [lane_health_pkg::EVT_W-1:0] evtEnable_reg;
  logic [lane_health_pkg::EVT_W-1:0] evtEnable_next;

  logic ack_reg;
  logic ack_next;
  logic [lane_health_pkg::DAT_W-1:0] rdData_reg;
  logic [lane_health_pkg::DAT_W-1:0] rdData_next;
  logic irq_reg;
  logic irq_next;
  logic statusValid_reg;

  // ----------------------------------------
  // Per-link status byte assembly
  // ----------------------------------------
  for (genvar gLink = 0; gLink < LINK_NUM; gLink++) begin : gen_link
    lane_error_compare #(
      .CNT_W(CNT_W)
    ) lane_error_compare_inst (
      .disparityCnt(linkLive[gLink].laneTwo.disparityCnt),
      .tableMissCnt(linkLive[gLink].laneTwo.tableMissCnt),
      .badCtrlCnt(linkLive[gLink].laneTwo.badCtrlCnt),
      .errorCountThreshold(errorCountThreshold),
      .disparityErr(linkTwoByte[gLink].disparityErr),
      .tableMissErr(linkTwoByte[gLink].tableMissErr),
      .badControlCharErr(linkTwoByte[gLink].badControlCharErr)
    );

    assign linkTwoByte[gLink].deskewDone = linkLive[gLink].laneTwo.deskewDone; // R04
    assign linkTwoByte[gLink].initialSyncOk = linkLive[gLink].laneTwo.initialSyncOk; // R05
    assign linkTwoByte[gLink].configSumOk = linkLive[gLink].laneTwo.configSumOk; // R06
    assign linkTwoByte[gLink].frameLock = linkLive[gLink].laneTwo.frameLock; // R07
    assign linkTwoByte[gLink].charGroupLock = linkLive[gLink].laneTwo.charGroupLock; // R08

    // Lane one carries only the three sync and checksum indications here
    assign linkOneByte[gLink].unused = '0;
    assign linkOneByte[gLink].configSumOk = linkLive[gLink].laneOne.configSumOk; // R09
    assign linkOneByte[gLink].frameLock = linkLive[gLink].laneOne.frameLock; // R09
    assign linkOneByte[gLink].charGroupLock = linkLive[gLink].laneOne.charGroupLock; // R09
  end

  // ----------------------------------------
  // Page selection
  // ----------------------------------------
  // A page beyond the built links shows all zero rather than aliasing another link
  wire pageInRange = (32'(linkPage_reg) < LINK_NUM);

  assign laneTwoSel = pageInRange ? linkTwoByte[linkPage_reg] : '0; // R10
  assign laneOneSel = pageInRange ? linkOneByte[linkPage_reg] : '0; // R10

  // Status bytes are resampled every cycle, never held from the past
  assign laneTwoHealth_next = laneTwoSel; // R11
  assign laneOneHealth_next = laneOneSel; // R11

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire [lane_health_pkg::IDX_W-1:0] regIdx = wb_adr_i[lane_health_pkg::ADR_W-1:2];
  wire busReq = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire busWrite = busReq & wb_we_i;
  wire lowLane = wb_sel_i[0];

  wire hitPage = (regIdx == lane_health_pkg::IDX_PAGE);
  wire hitLaneOne = (regIdx == lane_health_pkg::IDX_LANE_ONE);
  wire hitLaneTwo = (regIdx == lane_health_pkg::IDX_LANE_TWO);
  wire hitEvtStatus = (regIdx == lane_health_pkg::IDX_EVT_STATUS);
  wire hitEvtClear = (regIdx == lane_health_pkg::IDX_EVT_CLEAR);
  wire hitEvtEnable = (regIdx == lane_health_pkg::IDX_EVT_ENABLE);

  wire wrPage = busWrite & hitPage & lowLane;
  wire wrEvtClear = busWrite & hitEvtClear;
  wire wrEvtEnable = busWrite & hitEvtEnable;

  // Event registers span two byte lanes
  wire [lane_health_pkg::EVT_W-1:0] evtLaneMask = {
    {(lane_health_pkg::EVT_W - lane_health_pkg::BYTE_W){wb_sel_i[1]}},
    {lane_health_pkg::BYTE_W{wb_sel_i[0]}}
  };
  wire [lane_health_pkg::EVT_W-1:0] evtWrData = wb_dat_i[lane_health_pkg::EVT_W-1:0];

  // ----------------------------------------
  // Page register
  // ----------------------------------------
  assign linkPage_next = wrPage ? wb_dat_i[lane_health_pkg::PAGE_W-1:0] : linkPage_reg;

  // ----------------------------------------
  // Events
  // ----------------------------------------
  // A change of any status bit is an event; changes caused by a page switch count too
  wire [lane_health_pkg::EVT_W-1:0] liveVec = lane_health_pkg::event_vec_s'({
    laneOneHealth_reg[2:0],
    laneTwoHealth_reg
  });
  wire [lane_health_pkg::EVT_W-1:0] nextVec = lane_health_pkg::event_vec_s'({
    laneOneHealth_next[2:0],
    laneTwoHealth_next
  });
  // The first sample after reset is not compared against the reset zero; events start once valid
  wire [lane_health_pkg::EVT_W-1:0] evtHit = statusValid_reg ? (liveVec ^ nextVec) : '0;

  wire [lane_health_pkg::EVT_W-1:0] evtClearMask = wrEvtClear ? (evtWrData & evtLaneMask) : '0;

  // Set wins over a clear landing in the same cycle
  assign evtStatus_next = (evtStatus_reg & ~evtClearMask) | evtHit;

  assign evtEnable_next = wrEvtEnable ?
    ((evtEnable_reg & ~evtLaneMask) | (evtWrData & evtLaneMask)) : evtEnable_reg;

  assign irq_next = |(evtStatus_next & evtEnable_next);

  // ----------------------------------------
  // Read data and acknowledge
  // ----------------------------------------
  wire [lane_health_pkg::DAT_W-1:0] rdLaneTwo = lane_health_pkg::DAT_W'(laneTwoHealth_reg);
  wire [lane_health_pkg::DAT_W-1:0] rdLaneOne = lane_health_pkg::DAT_W'(laneOneHealth_reg);
  wire [lane_health_pkg::DAT_W-1:0] rdPage = lane_health_pkg::DAT_W'(linkPage_reg);
  wire [lane_health_pkg::DAT_W-1:0] rdEvtStatus = lane_health_pkg::DAT_W'(evtStatus_reg);
  wire [lane_health_pkg::DAT_W-1:0] rdEvtEnable = lane_health_pkg::DAT_W'(evtEnable_reg);

  // Status bytes accept writes on the bus but keep their live value
  wire [lane_health_pkg::DAT_W-1:0] rdMux =
    hitLaneTwo ? rdLaneTwo : // R10
    hitLaneOne ? rdLaneOne : // R10
    hitPage ? rdPage :
    hitEvtStatus ? rdEvtStatus :
    hitEvtEnable ? rdEvtEnable :
    lane_health_pkg::RST_DATA;

  // Unmapped and write-only addresses read as zero and are still acknowledged
  assign ack_next = busReq;
  assign rdData_next = (busReq & ~wb_we_i) ? rdMux : lane_health_pkg::RST_DATA;

  // ----------------------------------------
  // Status byte registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      laneTwoHealth_reg <= lane_health_pkg::RST_STATUS; // R10
      laneOneHealth_reg <= lane_health_pkg::RST_STATUS; // R10
      statusValid_reg <= 1'b0;
    end else begin
      laneTwoHealth_reg <= laneTwoHealth_next; // R11
      laneOneHealth_reg <= laneOneHealth_next; // R11
      statusValid_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      linkPage_reg <= lane_health_pkg::RST_PAGE;
      evtStatus_reg <= lane_health_pkg::RST_EVT;
      evtEnable_reg <= lane_health_pkg::RST_EVT;
      irq_reg <= 1'b0;
    end else begin
      linkPage_reg <= linkPage_next; // R10
      evtStatus_reg <= evtStatus_next;
      evtEnable_reg <= evtEnable_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // Bus answer registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
      rdData_reg <= lane_health_pkg::RST_DATA;
    end else begin
      ack_reg <= ack_next;
      rdData_reg <= rdData_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;
  assign irq = irq_reg;

endmodule

//--- dv/lane_rx_model.sv
// Receiver-side model: live state of each link's lanes
`timescale 1ns/100ps
module lane_rx_model (
  // Clock
  input wire logic ref_clk,
  // Live lane state
  output lane_health_pkg::link_live_s linkLive [lane_health_pkg::LINK_NUM]
);
  initial begin
    foreach (linkLive[i]) linkLive[i] = '0;
  end
  // State moves just after an edge, as the receiver's own flops would move it
  task automatic setLink(input int idx, input lane_health_pkg::link_live_s val);
    @(posedge ref_clk);
    linkLive[idx] <= val;
  endtask
endmodule

//--- dv/serial_lane_link_status_checker.sv
// Checker: bus handshake and status byte contents at the top ports
`timescale 1ns/100ps
module serial_lane_link_status_checker #(
  parameter int unsigned LINK_NUM = 2,
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Link side
  input wire lane_health_pkg::link_live_s linkLive [LINK_NUM],
  input wire logic [CNT_W-1:0] errorCountThreshold,
  input wire logic irq
);
  // ----
  // Page shadow, so a read knows which link it shows
  // ----
  logic pageReg;
  wire logic taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic [11:0] idx = wb_adr_i[13:2];
  wire lane_health_pkg::link_live_s selLive = linkLive[pageReg];
  wire logic [7:0] expTwo = {selLive.laneTwo.disparityCnt >= errorCountThreshold,
    selLive.laneTwo.tableMissCnt >= errorCountThreshold,
    selLive.laneTwo.badCtrlCnt >= errorCountThreshold, selLive.laneTwo[4:0]};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pageReg <= 1'b0;
    end else if (taken && wb_we_i && wb_sel_i[0] && idx == lane_health_pkg::IDX_PAGE) begin
      pageReg <= wb_dat_i[0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ----
  // Properties
  // ----
  // Live state must hold a while, since the bytes are a registered copy
  sequence s_steady;
    !$past(srst) && $stable(selLive) && $stable(pageReg) && $stable(errorCountThreshold);
  endsequence
  sequence s_read(logic [11:0] at);
    s_steady ##0 (taken && !wb_we_i && idx == at);
  endsequence
  property p_ack_next;
    taken |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
  property p_no_spur;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("ack without request");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_unmapped;
    taken && !wb_we_i && idx < lane_health_pkg::IDX_PAGE |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_two_read;
    s_read(lane_health_pkg::IDX_LANE_TWO) |=> wb_dat_o == {24'h00_0000, $past(expTwo)};
  endproperty
  a_two_read: assert property (p_two_read) else $error("lane two byte wrong");
  property p_one_read;
    s_read(lane_health_pkg::IDX_LANE_ONE) |=> wb_dat_o == {29'h0000_0000, $past(selLive.laneOne)};
  endproperty
  a_one_read: assert property (p_one_read) else $error("lane one byte wrong");
  property p_rst;
    disable iff (1'b0) srst |=> !wb_ack_o && wb_dat_o == 32'h0000_0000 && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind serial_lane_link_status serial_lane_link_status_checker #(
  .LINK_NUM(LINK_NUM),
  .CNT_W(CNT_W)
) serial_lane_link_status_checker_inst (
  .ref_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i,
  .wb_ack_o, .wb_dat_o, .linkLive, .errorCountThreshold, .irq
);

//--- dv/test_serial_lane_link_status.sv
// Testbench: lane status bank exercised through its register bus
`timescale 1ns/100ps
module test_serial_lane_link_status;
  localparam logic [13:0] A_PAGE = 14'h0c00;
  localparam logic [13:0] A_ONE = 14'h12c4;
  localparam logic [13:0] A_TWO = 14'h12c8;
  localparam logic [13:0] A_ST = 14'h1300;
  localparam logic [13:0] A_CLR = 14'h1304;
  localparam logic [13:0] A_EN = 14'h1308;
  logic ref_clk;
  logic srst;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [3:0] wbSel;
  logic [13:0] wbAdr;
  logic [31:0] wbDatW;
  logic wbAck;
  logic [31:0] wbDatR;
  logic irq;
  logic [7:0] thr;
  logic [31:0] rd;
  lane_health_pkg::lane_two_live_s lv;
  lane_health_pkg::link_live_s linkLive [lane_health_pkg::LINK_NUM];
  int n_fail;
  int checked;
  lane_rx_model lane_rx_model_inst (.ref_clk(ref_clk), .linkLive(linkLive));
  serial_lane_link_status serial_lane_link_status_inst (
    .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_sel_i(wbSel), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_ack_o(wbAck),
    .wb_dat_o(wbDatR), .linkLive(linkLive), .errorCountThreshold(thr), .irq(irq)
  );
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One classic cycle; a bounded wait so a dead slave cannot hang the run
  task automatic wbRw(input logic we, input logic [13:0] adr, input logic [31:0] dat);
    int n;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hf;
    wbAdr <= adr;
    wbDatW <= dat;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic rdCheck(input string what, input logic [13:0] adr, input logic [31:0] exp);
    wbRw(1'b0, adr, 32'h0000_0000);
    checkVal(what, exp, rd);
  endtask
  task automatic waitIrq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    checkVal("irq", {31'h0000_0000, exp}, {31'h0000_0000, irq});
    // A wait that ran out has already counted its mismatch
    if (irq !== exp) begin
      complete_run();
    end
  endtask
  function automatic logic [7:0] twoByte(input lane_health_pkg::lane_two_live_s v);
    return {v.disparityCnt >= thr, v.tableMissCnt >= thr, v.badCtrlCnt >= thr, v[4:0]};
  endfunction
  initial begin
    srst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbSel = 4'hf;
    wbAdr = 14'h0000;
    wbDatW = 32'h0000_0000;
    thr = 8'h10;
    n_fail = 0;
    checked = 0;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    // ----
    // Counts just below, at and above the threshold; every flag both ways except bad control (always set) and lane-one checksum (always clear)
    // ----
    for (int k = 0; k < 3; k++) begin
      lv = {thr - 8'h01 + 8'(k), thr + 8'h01 - 8'(k), thr + 8'(k), 5'(5'h15 << k)};
      lane_rx_model_inst.setLink(0, {3'(k + 1), lv});
      rdCheck("lane two", A_TWO, {24'h00_0000, twoByte(lv)});
      rdCheck("lane one", A_ONE, {29'h0000_0000, 3'(k + 1)});
    end
    // ----
    // Paging, ignored writes, unmapped read, no latching
    // ----
    lv = {8'hff, 8'h00, 8'h20, 5'h0b};
    lane_rx_model_inst.setLink(1, {3'h6, lv});
    wbRw(1'b1, A_PAGE, 32'h0000_0001);
    rdCheck("page", A_PAGE, 32'h0000_0001);
    rdCheck("lane two paged", A_TWO, {24'h00_0000, twoByte(lv)});
    rdCheck("lane one paged", A_ONE, 32'h0000_0006);
    wbRw(1'b1, A_TWO, 32'hffff_ffff);
    rdCheck("lane two written", A_TWO, {24'h00_0000, twoByte(lv)});
    rdCheck("unmapped", 14'h0004, 32'h0000_0000);
    wbRw(1'b1, A_PAGE, 32'h0000_0000);
    lane_rx_model_inst.setLink(0, '0);
    rdCheck("lane two released", A_TWO, 32'h0000_0000);
    // ----
    // Interrupt: raise, clear, mask
    // ----
    wbRw(1'b1, A_EN, 32'h0000_0002);
    rdCheck("enable", A_EN, 32'h0000_0002);
    wbRw(1'b1, A_CLR, 32'h0000_07ff);
    waitIrq(1'b0);
    lane_rx_model_inst.setLink(0, {3'h0, 24'h00_0000, 5'h02});
    waitIrq(1'b1);
    rdCheck("events", A_ST, 32'h0000_0002);
    wbRw(1'b1, A_CLR, 32'h0000_0002);
    waitIrq(1'b0);
    wbRw(1'b1, A_EN, 32'h0000_0000);
    lane_rx_model_inst.setLink(0, '0);
    repeat (4) @(posedge ref_clk);
    checkVal("masked irq", 32'h0000_0000, {31'h0000_0000, irq});
    rdCheck("masked events", A_ST, 32'h0000_0002);
    complete_run();
  end
endmodule
